//--- src/preempt_pkg.sv
package preempt_pkg;
  // preempt count and widths
  localparam int NPRE = 10;
  localparam int AW = 8;

  // register byte addresses
  localparam logic [AW-1:0] A_STATUS = 8'h00;
  localparam logic [AW-1:0] A_TIME0 = 8'h04;
  localparam logic [AW-1:0] A_TIME1 = 8'h08;
  localparam logic [AW-1:0] A_TIME2 = 8'h0c;
  localparam logic [AW-1:0] A_DWELL_PH = 8'h10;
  localparam logic [AW-1:0] A_EXIT_PH = 8'h14;
  localparam logic [AW-1:0] A_TRK_OVL = 8'h18;
  localparam logic [AW-1:0] A_DWL_OVL = 8'h1c;
  localparam logic [AW-1:0] A_CFG = 8'h40;

  // time0 / time1 / time2 field positions
  localparam int T0_DELAY = 0;
  localparam int T0_MINDUR = 16;
  localparam int T1_MINDWELL = 0;
  localparam int T1_TRACK = 8;
  localparam int T1_EXTEND = 16;
  localparam int T1_RETURN = 24;
  localparam int T2_WALKER_CLEARANCE_TIME = 0;
  localparam int T2_YEL = 8;
  localparam int T2_RED = 16;
  localparam int T2_PATTERN = 24;
  localparam int T2_RETMAX = 31;

  // per-preempt config word fields
  localparam int CF_EN = 0;
  localparam int CF_LOCK = 1;
  localparam int CF_OVRF = 2;
  localparam int CF_OVRH = 3;
  localparam int CF_SKIP = 4;
  localparam int CF_FID = 5;
  localparam int CF_MODE = 6;
  localparam int CF_LINK = 8;
  localparam int CF_RAIL = 12;

  // active-output modes
  localparam logic [1:0] OM_RECOG = 2'h0;
  localparam logic [1:0] OM_DELAY = 2'h1;
  localparam logic [1:0] OM_DWELL = 2'h2;

  // reset values and bus answers
  localparam logic [31:0] RST_WORD = 32'h0;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_DELAY = 3'h1,
    ST_TRACK = 3'h3,
    ST_DWELL = 3'h2,
    ST_EXIT_PED = 3'h6,
    ST_EXIT_YEL = 3'h7,
    ST_EXIT_RED = 3'h5,
    ST_RETURN = 3'h4
  } seq_e;
endpackage

//--- src/tick_timer.sv
module tick_timer #(
  parameter int W = 8
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // control
  input wire logic load,
  input wire logic [W-1:0] val,
  input wire logic tick,
  // status
  output logic done
);
  logic [W-1:0] cnt_r;
  logic [W-1:0] cnt_nxt;

  always_comb begin
    cnt_nxt = cnt_r;
    if (load) begin
      cnt_nxt = val;
    end else if (tick && cnt_r != '0) begin
      cnt_nxt = cnt_r - 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_r <= '0;
    end else begin
      cnt_r <= cnt_nxt;
    end
  end

  assign done = (cnt_r == '0);
endmodule

//--- src/preemption_sequencer.sv
// Behaviour
// [R1] lock latches call through delay and minimums
// [R2] after minimums, locked call follows input
// [R3] unlocked call dropped in delay aborts
// [R4] minimum dwell and duration guaranteed unless an override preempt cuts them short
// [R5] flash override: end flash, preempt, resume
// [R6] no override: ignore calls during flash
// [R7] lowest number has highest priority
// [R8] override setting lets preempt interrupt higher numbers
// [R9] higher number never interrupts lower number
// [R10] flash in dwell: yellow dwell, red others
// [R11] link target called while origin demand stays
// [R12] dwell extension stretches call 0-255 s
// [R13] return time as exit max or min
// [R14] exit ped, yellow, red clearances
// [R15] overlaps red during track and dwell
// [R16] 32 overlaps enabled per group
// [R17] preempt enable gates the input
// [R18] active output in three timing modes
// [R19] pattern invoked after delay unless coord
// [R20] pattern keeps coordination inactive
// [R21] skip track when overriding, if set
// [R22] exit list of 8 phases
// [R23] delay 0-600 s before track and dwell
// [R24] second tick timers, tenth tick clearances; exit ped clearance counts tick_1s
module preemption_sequencer
  import preempt_pkg::*;
(
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite write
  input wire logic [preempt_pkg::AW-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  // axi4-lite read
  input wire logic [preempt_pkg::AW-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // detector calls and controller conditions
  input wire logic [preempt_pkg::NPRE-1:0] preempt_in,
  input wire logic tick_1s,
  input wire logic tick_100ms,
  input wire logic auto_flash,
  input wire logic coord_with_preempt,
  // sequencer outputs
  output logic [preempt_pkg::NPRE-1:0] preempt_active,
  output logic [2:0] seq_state,
  output logic [3:0] active_num,
  output logic flash_suspend,
  output logic [31:0] flash_yellow,
  output logic [31:0] flash_red,
  output logic [31:0] overlap_red,
  output logic [7:0] exit_phases,
  output logic return_is_max,
  output logic [7:0] return_time,
  output logic [4:0] pattern_sel,
  output logic coord_inhibit
);
  import preempt_pkg::*;

  // bus state
  logic awready_r, awready_nxt, wready_r, wready_nxt;
  logic aw_have_r, aw_have_nxt, w_have_r, w_have_nxt;
  logic [AW-1:0] waddr_r, waddr_nxt;
  logic [31:0] wdat_r, wdat_nxt;
  logic [3:0] wstb_r, wstb_nxt;
  logic bvalid_r, bvalid_nxt, arready_r, arready_nxt, rvalid_r, rvalid_nxt;
  logic [1:0] bresp_r, bresp_nxt, rresp_r, rresp_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic do_wr;

  // register file
  logic [31:0] time0_r, time1_r, time2_r, dwell_ph_r, exit_ph_r, trk_ovl_r, dwl_ovl_r;
  logic [31:0] time0_nxt, time1_nxt, time2_nxt, dwell_ph_nxt, exit_ph_nxt;
  logic [31:0] trk_ovl_nxt, dwl_ovl_nxt;
  logic [31:0] cfg_r [NPRE];
  logic [31:0] cfg_nxt [NPRE];

  // sequencer state
  seq_e state_r, state_nxt;
  logic [3:0] act_r, act_nxt, link_src_r, link_src_nxt, link_dst_r, link_dst_nxt;
  logic ovr_r, ovr_nxt, link_on_r, link_on_nxt;
  logic [NPRE-1:0] lock_r, lock_nxt, call_v, ext_live;
  logic seq_load, md_load, seq_done, md_done, seq_tick;
  logic [15:0] seq_val;
  logic [3:0] best, cand, link_tgt;
  logic any_call, any_cand;

  // registered outputs
  logic [NPRE-1:0] pa_r, pa_nxt;
  logic fsusp_r, fsusp_nxt, ret_max_r, ret_max_nxt, coord_inh_r, coord_inh_nxt;
  logic [31:0] fyel_r, fyel_nxt, fred_r, fred_nxt, ovl_red_r, ovl_red_nxt;
  logic [7:0] exitp_r, exitp_nxt, ret_time_r, ret_time_nxt;
  logic [4:0] pat_r, pat_nxt;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
                                        input logic [3:0] s);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (s[b]) begin
        r[b*8 +: 8] = d[b*8 +: 8];
      end
    end
    return r;
  endfunction

  function automatic logic mapped(input logic [AW-1:0] a);
    return (a[1:0] == 2'h0) && ((a <= A_DWL_OVL) ||
           (a >= A_CFG && a < A_CFG + AW'(4 * NPRE)));
  endfunction

  // dwell extension, one stretch timer per input
  for (genvar g = 0; g < NPRE; g++) begin : g_ext
    logic ext_done;
    tick_timer #(.W(8)) u_ext (
      .aclk(aclk),
      .aresetn(aresetn),
      .load(preempt_in[g]),
      .val(time1_r[T1_EXTEND +: 8]),
      .tick(tick_1s),
      .done(ext_done)
    );
    assign ext_live[g] = preempt_in[g] | ~ext_done; // R12
  end

  // interval timer: seconds, exit yellow and red clearances in tenths
  tick_timer #(.W(16)) u_seq (
    .aclk(aclk),
    .aresetn(aresetn),
    .load(seq_load),
    .val(seq_val),
    .tick(seq_tick),
    .done(seq_done)
  );

  tick_timer #(.W(14)) u_md (
    .aclk(aclk),
    .aresetn(aresetn),
    .load(md_load),
    .val(time0_r[T0_MINDUR +: 14]),
    .tick(tick_1s),
    .done(md_done)
  );

  // axi4-lite slave
  always_comb begin
    aw_have_nxt = aw_have_r;
    w_have_nxt = w_have_r;
    waddr_nxt = waddr_r;
    wdat_nxt = wdat_r;
    wstb_nxt = wstb_r;
    bvalid_nxt = bvalid_r;
    bresp_nxt = bresp_r;
    rvalid_nxt = rvalid_r;
    rresp_nxt = rresp_r;
    rdata_nxt = rdata_r;
    if (awvalid && awready_r) begin
      aw_have_nxt = 1'b1;
      waddr_nxt = awaddr;
    end
    if (wvalid && wready_r) begin
      w_have_nxt = 1'b1;
      wdat_nxt = wdata;
      wstb_nxt = wstrb;
    end
    do_wr = aw_have_r && w_have_r && !bvalid_r;
    if (bvalid_r && bready) begin
      bvalid_nxt = 1'b0;
    end
    if (do_wr) begin
      aw_have_nxt = 1'b0;
      w_have_nxt = 1'b0;
      bvalid_nxt = 1'b1;
      bresp_nxt = mapped(waddr_r) ? RESP_OKAY : RESP_SLVERR;
    end
    if (rvalid_r && rready) begin
      rvalid_nxt = 1'b0;
    end
    if (arvalid && arready_r) begin
      rvalid_nxt = 1'b1;
      rresp_nxt = mapped(araddr) ? RESP_OKAY : RESP_SLVERR;
      case (araddr)
        A_STATUS: rdata_nxt = {3'h0, pa_r, call_v, act_r, 1'b0, ovr_r, state_r};
        A_TIME0: rdata_nxt = time0_r;
        A_TIME1: rdata_nxt = time1_r;
        A_TIME2: rdata_nxt = time2_r;
        A_DWELL_PH: rdata_nxt = dwell_ph_r;
        A_EXIT_PH: rdata_nxt = exit_ph_r;
        A_TRK_OVL: rdata_nxt = trk_ovl_r;
        A_DWL_OVL: rdata_nxt = dwl_ovl_r;
        default: begin
          rdata_nxt = RST_WORD;
          for (int i = 0; i < NPRE; i++) begin
            if (araddr == A_CFG + AW'(4 * i)) begin
              rdata_nxt = cfg_r[i];
            end
          end
        end
      endcase
    end
    awready_nxt = !aw_have_nxt && !bvalid_nxt;
    wready_nxt = !w_have_nxt && !bvalid_nxt;
    arready_nxt = !rvalid_nxt;
  end

  // register writes with byte strobes
  always_comb begin
    time0_nxt = time0_r;
    time1_nxt = time1_r;
    time2_nxt = time2_r;
    dwell_ph_nxt = dwell_ph_r;
    exit_ph_nxt = exit_ph_r;
    trk_ovl_nxt = trk_ovl_r;
    dwl_ovl_nxt = dwl_ovl_r;
    cfg_nxt = cfg_r;
    if (do_wr) begin
      case (waddr_r)
        A_TIME0: time0_nxt = merge(time0_r, wdat_r, wstb_r) & 32'h3fff_03ff; // R23
        A_TIME1: time1_nxt = merge(time1_r, wdat_r, wstb_r);
        A_TIME2: time2_nxt = merge(time2_r, wdat_r, wstb_r) & 32'h9fff_ffff;
        A_DWELL_PH: dwell_ph_nxt = merge(dwell_ph_r, wdat_r, wstb_r);
        A_EXIT_PH: exit_ph_nxt = merge(exit_ph_r, wdat_r, wstb_r) & 32'h0000_00ff; // R22
        A_TRK_OVL: trk_ovl_nxt = merge(trk_ovl_r, wdat_r, wstb_r); // R16
        A_DWL_OVL: dwl_ovl_nxt = merge(dwl_ovl_r, wdat_r, wstb_r); // R16
        default: begin
          for (int i = 0; i < NPRE; i++) begin
            if (waddr_r == A_CFG + AW'(4 * i)) begin
              cfg_nxt[i] = merge(cfg_r[i], wdat_r, wstb_r) & 32'h0000_1fff;
            end
          end
        end
      endcase
    end
  end

  // call qualification and arbitration
  always_comb begin
    for (int i = 0; i < NPRE; i++) begin
      call_v[i] = cfg_r[i][CF_EN] // R17
                  && (ext_live[i] || lock_r[i] // R1
                      || (link_on_r && link_dst_r == 4'(i))) // R11
                  && !(auto_flash && !cfg_r[i][CF_OVRF]); // R6
    end
    best = 4'h0;
    any_call = 1'b0;
    cand = 4'h0;
    any_cand = 1'b0;
    for (int i = NPRE - 1; i >= 0; i--) begin
      if (call_v[i]) begin
        best = 4'(i); // R7
        any_call = 1'b1;
      end
      if (call_v[i] && cfg_r[i][CF_OVRH] && 4'(i) < act_r) begin
        cand = 4'(i); // R8 R9
        any_cand = 1'b1;
      end
    end
    link_tgt = cfg_r[act_r][CF_LINK +: 4];
  end

  // sequencer
  always_comb begin
    state_nxt = state_r;
    act_nxt = act_r;
    ovr_nxt = ovr_r;
    link_on_nxt = link_on_r && ext_live[link_src_r]; // R11
    link_src_nxt = link_src_r;
    link_dst_nxt = link_dst_r;
    pat_nxt = pat_r;
    coord_inh_nxt = coord_inh_r;
    seq_load = 1'b0;
    seq_val = 16'h0;
    md_load = 1'b0;
    seq_tick = (state_r == ST_EXIT_YEL || state_r == ST_EXIT_RED) ? tick_100ms : tick_1s; // R24
    for (int i = 0; i < NPRE; i++) begin
      lock_nxt[i] = lock_r[i] || (cfg_r[i][CF_LOCK] && cfg_r[i][CF_EN] && preempt_in[i]);
    end
    if (state_r == ST_DWELL && seq_done && md_done) begin
      lock_nxt[act_r] = 1'b0; // R2
    end
    if (state_r != ST_IDLE && any_cand) begin
      act_nxt = cand;
      ovr_nxt = 1'b1;
      state_nxt = ST_DELAY;
      seq_load = 1'b1;
      seq_val = {6'h0, time0_r[T0_DELAY +: 10]};
    end else begin
      case (state_r)
        ST_IDLE: begin
          pat_nxt = 5'h0;
          coord_inh_nxt = 1'b0;
          ovr_nxt = 1'b0;
          if (any_call) begin
            act_nxt = best;
            state_nxt = ST_DELAY;
            seq_load = 1'b1;
            seq_val = {6'h0, time0_r[T0_DELAY +: 10]}; // R23
          end
        end
        ST_DELAY: begin
          if (!call_v[act_r]) begin
            state_nxt = ST_IDLE; // R3
          end else if (seq_done) begin
            md_load = 1'b1;
            seq_load = 1'b1;
            if (!coord_with_preempt && time2_r[T2_PATTERN +: 5] != 5'h0) begin
              pat_nxt = time2_r[T2_PATTERN +: 5]; // R19
              coord_inh_nxt = 1'b1; // R20
            end
            if ((ovr_r && cfg_r[act_r][CF_SKIP]) || time1_r[T1_TRACK +: 8] == 8'h0) begin
              state_nxt = ST_DWELL; // R21
              seq_val = {8'h0, time1_r[T1_MINDWELL +: 8]};
            end else begin
              state_nxt = ST_TRACK;
              seq_val = {8'h0, time1_r[T1_TRACK +: 8]};
            end
          end
        end
        ST_TRACK: begin
          if (seq_done) begin
            state_nxt = ST_DWELL;
            seq_load = 1'b1;
            seq_val = {8'h0, time1_r[T1_MINDWELL +: 8]};
          end
        end
        ST_DWELL: begin
          if (seq_done && md_done && !call_v[act_r]) begin
            state_nxt = ST_EXIT_PED; // R4
            seq_load = 1'b1;
            seq_val = {8'h0, time2_r[T2_WALKER_CLEARANCE_TIME +: 8]}; // R14
          end
        end
        ST_EXIT_PED: begin
          if (seq_done) begin
            state_nxt = ST_EXIT_YEL;
            seq_load = 1'b1;
            seq_val = {8'h0, time2_r[T2_YEL +: 8]}; // R14
          end
        end
        ST_EXIT_YEL: begin
          if (seq_done) begin
            state_nxt = ST_EXIT_RED;
            seq_load = 1'b1;
            seq_val = {8'h0, time2_r[T2_RED +: 8]}; // R14
          end
        end
        ST_EXIT_RED: begin
          if (seq_done) begin
            state_nxt = ST_RETURN;
            seq_load = 1'b1;
            seq_val = {8'h0, time1_r[T1_RETURN +: 8]}; // R13
          end
        end
        ST_RETURN: begin
          if (seq_done) begin
            state_nxt = ST_IDLE;
            if (link_tgt != 4'h0 && link_tgt <= 4'(NPRE)) begin
              link_on_nxt = 1'b1; // R11
              link_src_nxt = act_r;
              link_dst_nxt = link_tgt - 4'h1;
            end
          end
        end
        default: state_nxt = ST_IDLE;
      endcase
    end
  end

  // output staging
  always_comb begin
    for (int i = 0; i < NPRE; i++) begin
      pa_nxt[i] = 1'b0;
      if (act_nxt == 4'(i)) begin
        case (cfg_r[i][CF_MODE +: 2]) // R18
          OM_DELAY: pa_nxt[i] = state_nxt != ST_IDLE;
          OM_DWELL: pa_nxt[i] = state_nxt == ST_DWELL;
          default: pa_nxt[i] = state_nxt != ST_IDLE && state_nxt != ST_DELAY;
        endcase
      end
    end
    // flash held off while a preempt runs; released on return to idle
    fsusp_nxt = (fsusp_r || (auto_flash && state_nxt != ST_IDLE))
                && state_nxt != ST_IDLE; // R5
    fyel_nxt = 32'h0;
    fred_nxt = 32'h0;
    if (state_nxt == ST_DWELL && cfg_r[act_nxt][CF_FID]) begin
      fyel_nxt = dwell_ph_r; // R10
      fred_nxt = ~dwell_ph_r; // R10
    end
    case (state_nxt)
      ST_TRACK: ovl_red_nxt = ~trk_ovl_r; // R15
      ST_DWELL: ovl_red_nxt = ~dwl_ovl_r; // R15
      default: ovl_red_nxt = 32'h0;
    endcase
    exitp_nxt = (state_nxt == ST_RETURN) ? exit_ph_r[7:0] : 8'h0; // R22
    ret_time_nxt = time1_r[T1_RETURN +: 8];
    ret_max_nxt = time2_r[T2_RETMAX]; // R13
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready_r <= 1'b0;
      wready_r <= 1'b0;
      aw_have_r <= 1'b0;
      w_have_r <= 1'b0;
      waddr_r <= '0;
      wdat_r <= RST_WORD;
      wstb_r <= 4'h0;
      bvalid_r <= 1'b0;
      bresp_r <= RESP_OKAY;
      arready_r <= 1'b0;
      rvalid_r <= 1'b0;
      rresp_r <= RESP_OKAY;
      rdata_r <= RST_WORD;
      time0_r <= RST_WORD;
      time1_r <= RST_WORD;
      time2_r <= RST_WORD;
      dwell_ph_r <= RST_WORD;
      exit_ph_r <= RST_WORD;
      trk_ovl_r <= RST_WORD;
      dwl_ovl_r <= RST_WORD;
      for (int i = 0; i < NPRE; i++) begin
        cfg_r[i] <= RST_WORD;
      end
      state_r <= ST_IDLE;
      act_r <= 4'h0;
      ovr_r <= 1'b0;
      link_on_r <= 1'b0;
      link_src_r <= 4'h0;
      link_dst_r <= 4'h0;
      lock_r <= '0;
      pa_r <= '0;
      fsusp_r <= 1'b0;
      fyel_r <= 32'h0;
      fred_r <= 32'h0;
      ovl_red_r <= 32'h0;
      exitp_r <= 8'h0;
      ret_time_r <= 8'h0;
      ret_max_r <= 1'b0;
      pat_r <= 5'h0;
      coord_inh_r <= 1'b0;
    end else begin
      awready_r <= awready_nxt;
      wready_r <= wready_nxt;
      aw_have_r <= aw_have_nxt;
      w_have_r <= w_have_nxt;
      waddr_r <= waddr_nxt;
      wdat_r <= wdat_nxt;
      wstb_r <= wstb_nxt;
      bvalid_r <= bvalid_nxt;
      bresp_r <= bresp_nxt;
      arready_r <= arready_nxt;
      rvalid_r <= rvalid_nxt;
      rresp_r <= rresp_nxt;
      rdata_r <= rdata_nxt;
      time0_r <= time0_nxt;
      time1_r <= time1_nxt;
      time2_r <= time2_nxt;
      dwell_ph_r <= dwell_ph_nxt;
      exit_ph_r <= exit_ph_nxt;
      trk_ovl_r <= trk_ovl_nxt;
      dwl_ovl_r <= dwl_ovl_nxt;
      cfg_r <= cfg_nxt;
      state_r <= state_nxt;
      act_r <= act_nxt;
      ovr_r <= ovr_nxt;
      link_on_r <= link_on_nxt;
      link_src_r <= link_src_nxt;
      link_dst_r <= link_dst_nxt;
      lock_r <= lock_nxt;
      pa_r <= pa_nxt;
      fsusp_r <= fsusp_nxt;
      fyel_r <= fyel_nxt;
      fred_r <= fred_nxt;
      ovl_red_r <= ovl_red_nxt;
      exitp_r <= exitp_nxt;
      ret_time_r <= ret_time_nxt;
      ret_max_r <= ret_max_nxt;
      pat_r <= pat_nxt;
      coord_inh_r <= coord_inh_nxt;
    end
  end

  assign awready = awready_r;
  assign wready = wready_r;
  assign bvalid = bvalid_r;
  assign bresp = bresp_r;
  assign arready = arready_r;
  assign rvalid = rvalid_r;
  assign rresp = rresp_r;
  assign rdata = rdata_r;
  assign preempt_active = pa_r;
  assign seq_state = state_r;
  assign active_num = act_r;
  assign flash_suspend = fsusp_r;
  assign flash_yellow = fyel_r;
  assign flash_red = fred_r;
  assign overlap_red = ovl_red_r;
  assign exit_phases = exitp_r;
  assign return_is_max = ret_max_r;
  assign return_time = ret_time_r;
  assign pattern_sel = pat_r;
  assign coord_inhibit = coord_inh_r;
endmodule

//--- sim/preempt_props.sv
module preempt_props
  import preempt_pkg::*;
(
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // bus answers
  input wire logic arready,
  input wire logic [1:0] bresp,
  input wire logic bvalid,
  input wire logic bready,
  input wire logic [31:0] rdata,
  input wire logic rvalid,
  input wire logic rready,
  // sequencer
  input wire logic auto_flash,
  input wire logic [preempt_pkg::NPRE-1:0] preempt_active,
  input wire logic [2:0] seq_state,
  input wire logic flash_suspend,
  input wire logic [31:0] flash_yellow,
  input wire logic [31:0] flash_red,
  input wire logic [31:0] overlap_red,
  input wire logic [7:0] exit_phases,
  input wire logic [4:0] pattern_sel,
  input wire logic coord_inhibit
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  AST_B_HOLD: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("write response left early");
  AST_R_HOLD: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
    else $error("read data left early");
  AST_AR_BLOCK: assert property (rvalid |-> !arready)
    else $error("read address taken while data pending");
  AST_IDLE_OFF: assert property (seq_state == ST_IDLE |-> preempt_active == '0)
    else $error("active output while idle");
  AST_OVL_QUIET: assert property (!(seq_state inside {ST_TRACK, ST_DWELL}) |-> overlap_red == '0)
    else $error("overlaps held outside track and dwell");
  AST_EXIT_ONLY: assert property (seq_state != ST_RETURN |-> exit_phases == '0)
    else $error("exit list outside return");
  AST_FLASH_SPLIT: assert property ((flash_yellow & flash_red) == '0)
    else $error("phase flashes both colours");
  AST_YEL_ORDER: assert property ($changed(seq_state) && seq_state == ST_EXIT_YEL |-> $past(seq_state) == ST_EXIT_PED)
    else $error("exit yellow not after exit ped");
  AST_DWELL_ENTRY: assert property ($changed(seq_state) && seq_state == ST_DWELL |-> $past(seq_state) inside {ST_DELAY, ST_TRACK})
    else $error("dwell entered without delay");
  AST_FLASH_HOLD: assert property ($rose(flash_suspend) |-> $past(auto_flash))
    else $error("flash suspended without flash");
  AST_PAT_COORD: assert property (pattern_sel != '0 |-> coord_inhibit)
    else $error("pattern applied with coordination on");
endmodule

bind preemption_sequencer preempt_props chk_i (.aclk, .aresetn, .arready, .bresp, .bvalid,
  .bready, .rdata, .rvalid, .rready, .auto_flash, .preempt_active, .seq_state, .flash_suspend,
  .flash_yellow, .flash_red, .overlap_red, .exit_phases, .pattern_sel, .coord_inhibit);

//--- sim/detector_model.sv
module detector_model (
  // clock
  input wire logic aclk,
  // vehicle demand and detector contacts
  input wire logic [9:0] demand,
  output logic [9:0] preempt_in = '0
);
  timeunit 1ns;
  timeprecision 1ps;
  // contacts settle one clock after the demand changes
  always @(posedge aclk) begin
    preempt_in <= demand;
  end
endmodule

//--- sim/preemption_sequencer_bench.sv
module preemption_sequencer_bench;
  import preempt_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic [7:0] awaddr = '0, araddr = '0;
  logic [31:0] wdata = '0, rdata, flash_yellow, flash_red, overlap_red, d;
  logic [3:0] wstrb = '0, active_num;
  logic tick_1s = 0, tick_100ms = 0, auto_flash = 0, coord_with_preempt = 0;
  logic awready, wready, bvalid, arready, rvalid, return_is_max, coord_inhibit, flash_suspend;
  logic [1:0] bresp, rresp, r;
  logic [9:0] demand = '0, preempt_in, preempt_active;
  logic [2:0] seq_state;
  logic [7:0] exit_phases, return_time;
  logic [4:0] pattern_sel;
  int fails = 0, num_checks = 0, tcnt = 0;

  always #5 aclk = ~aclk;
  // fast ticks keep second-based timing short
  always @(posedge aclk) begin
    tcnt <= (tcnt == 19) ? 0 : tcnt + 1;
    tick_1s <= (tcnt == 19);
    tick_100ms <= tcnt[0];
  end

  detector_model det (.aclk, .demand, .preempt_in);
  preemption_sequencer uut (.aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb,
    .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp,
    .rvalid, .rready, .preempt_in, .tick_1s, .tick_100ms, .auto_flash, .coord_with_preempt,
    .preempt_active, .seq_state, .active_num, .flash_suspend, .flash_yellow, .flash_red,
    .overlap_red, .exit_phases, .return_is_max, .return_time, .pattern_sel, .coord_inhibit);

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic summarize();
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  task automatic lost();
    fails++;
    $display("CHECK FAILED %0t: wait ran out", $time);
    summarize();
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    int n;
    n = 0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= v;
    wstrb <= 4'hf;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (n > 50) lost();
    end while (!bvalid);
    r = bresp;
    bready <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a);
    int n;
    n = 0;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (arready) arvalid <= 1'b0;
      if (n > 50) lost();
    end while (!rvalid);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask

  task automatic wait_st(input logic [2:0] s);
    int n;
    n = 0;
    while (seq_state !== s) begin
      @(posedge aclk);
      n++;
      if (n > 400) lost();
    end
  endtask

  initial begin
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    rd(A_TIME1);
    chk(d, RST_WORD);
    rd(8'h20);
    chk(d, 32'h0);
    chk(32'(r), 32'(RESP_SLVERR));
    wr(8'h24, 32'h1);
    chk(32'(r), 32'(RESP_SLVERR));
    wr(A_TIME1, 32'h0200_0000);
    rd(A_TIME1);
    chk(d, 32'h0200_0000);
    $display("registers done");
    // dwell displays, pattern and exit
    wr(A_TIME2, 32'h8500_0000);
    wr(A_DWELL_PH, 32'h0000_00f0);
    wr(A_EXIT_PH, 32'h0000_00a5);
    wr(A_DWL_OVL, 32'h0000_0003);
    wr(A_CFG, 32'h0000_0061);
    demand <= 10'h001;
    wait_st(ST_DWELL);
    repeat (2) @(posedge aclk);
    chk(flash_yellow, 32'h0000_00f0);
    chk(flash_red, 32'hffff_ff0f);
    chk(overlap_red, 32'hffff_fffc);
    chk(32'(preempt_active), 32'h1);
    chk(32'(pattern_sel), 32'h5);
    chk(32'(coord_inhibit), 32'h1);
    demand <= '0;
    wait_st(ST_RETURN);
    @(posedge aclk);
    chk(32'(exit_phases), 32'ha5);
    chk({return_is_max, 23'h0, return_time}, 32'h8000_0002);
    wait_st(ST_IDLE);
    $display("dwell and exit done");
    // locking against a call dropped in delay
    wr(A_TIME0, 32'h0000_0002);
    wr(A_CFG, 32'h0000_0001);
    demand <= 10'h001;
    wait_st(ST_DELAY);
    demand <= '0;
    chk(32'(preempt_active), 32'h0);
    repeat (40) @(posedge aclk);
    chk(32'(seq_state), 32'(ST_IDLE));
    wr(A_CFG, 32'h0000_0003);
    demand <= 10'h001;
    wait_st(ST_DELAY);
    demand <= '0;
    wait_st(ST_DWELL);
    @(posedge aclk);
    chk(32'(preempt_active), 32'h1);
    wait_st(ST_IDLE);
    wr(A_TIME0, 32'h0);
    $display("locking done");
    // disabled preempt
    demand <= 10'h008;
    repeat (20) @(posedge aclk);
    chk(32'(seq_state), 32'(ST_IDLE));
    demand <= '0;
    // automatic flash
    auto_flash <= 1'b1;
    wr(A_CFG, 32'h0000_0001);
    demand <= 10'h001;
    repeat (20) @(posedge aclk);
    chk(32'(seq_state), 32'(ST_IDLE));
    wr(A_CFG, 32'h0000_0005);
    wait_st(ST_DWELL);
    @(posedge aclk);
    chk(32'(flash_suspend), 32'h1);
    demand <= '0;
    wait_st(ST_IDLE);
    @(posedge aclk);
    chk(32'(flash_suspend), 32'h0);
    auto_flash <= 1'b0;
    $display("flash done");
    // priority among preempts
    wr(A_CFG, 32'h0000_0001);
    wr(A_CFG + 8'h04, 32'h0000_0001);
    wr(A_CFG + 8'h08, 32'h0000_0009);
    demand <= 10'h002;
    wait_st(ST_DWELL);
    demand <= 10'h007;
    repeat (20) @(posedge aclk);
    chk(32'(active_num), 32'h1);
    wr(A_CFG, 32'h0000_0009);
    repeat (5) @(posedge aclk);
    chk(32'(active_num), 32'h0);
    demand <= '0;
    wait_st(ST_IDLE);
    $display("priority done");
    // skip on override, extension, tenth-second clearances, link
    wr(A_TIME1, 32'h0200_0500);
    wr(A_CFG, 32'h0000_0019);
    demand <= 10'h002;
    wait_st(ST_TRACK);
    demand <= 10'h003;
    repeat (10) @(posedge aclk);
    chk(32'(seq_state), 32'(ST_DWELL));
    demand <= '0;
    wait_st(ST_IDLE);
    wr(A_TIME1, 32'h0203_0000);
    wr(A_TIME2, 32'h0000_0a00);
    wr(A_CFG + 8'h04, 32'h0000_0101);
    demand <= 10'h002;
    wait_st(ST_DWELL);
    demand <= '0;
    repeat (30) @(posedge aclk);
    chk(32'(seq_state), 32'(ST_DWELL));
    wait_st(ST_EXIT_YEL);
    demand <= 10'h002;
    repeat (15) @(posedge aclk);
    chk(32'(seq_state), 32'(ST_EXIT_YEL));
    repeat (10) @(posedge aclk);
    chk(32'(seq_state), 32'(ST_RETURN));
    wait_st(ST_IDLE);
    repeat (3) @(posedge aclk);
    chk(32'(active_num), 32'h0);
    demand <= '0;
    wait_st(ST_IDLE);
    $display("override and link done");
    summarize();
  end
endmodule
